// [shared/hvac_keypad_pkg.sv]
// Constants, encodings and register map of the climate panel keypad controller.
// Assumes a 100 MHz system clock; slow timing runs on a coarse tick.
`default_nettype none
package hvac_keypad_pkg;
   localparam int unsigned CLK_HZ     = 100_000_000;
   localparam int unsigned TICK_US    = 10_000;
   localparam int unsigned TICK_CYC   = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int unsigned DEB_MS     = 20;
   localparam int unsigned DEB_TK     = DEB_MS * 1000 / TICK_US;
   localparam int unsigned REP_MS     = 500;
   localparam int unsigned REP_TK     = REP_MS * 1000 / TICK_US;
   localparam int unsigned HOLD_S     = 5;
   localparam int unsigned HOLD_TK    = HOLD_S * 1_000_000 / TICK_US;
   localparam int unsigned FUNC_S     = 5;
   localparam int unsigned FUNC_TK    = FUNC_S * 1_000_000 / TICK_US;
   localparam int unsigned ROT_S      = 2;
   localparam int unsigned ROT_TK     = ROT_S * 1_000_000 / TICK_US;
   localparam int unsigned BLOW_MIN   = 2;
   localparam int unsigned BLOW_TK    = BLOW_MIN * 60 * 1_000_000 / TICK_US;
   localparam int unsigned HOUR_S     = 3600;
   localparam int unsigned HOUR_TK    = HOUR_S * 1_000_000 / TICK_US;
   localparam int unsigned HALFH_TK   = HOUR_TK / 2;

   localparam logic [4:0] SP_MIN      = 5'h10;
   localparam logic [4:0] SP_MAX      = 5'h1e;
   localparam logic [4:0] SP_RST      = 5'h18;
   localparam logic [5:0] TMR_MIN     = 6'h01;
   localparam logic [5:0] TMR_MAX     = 6'h30;
   localparam logic [5:0] TMR_RST     = 6'h02;
   localparam logic [1:0] DRIFT_MAX   = 2'h2;

   localparam int unsigned B_PWR = 0;
   localparam int unsigned B_MODE = 1;
   localparam int unsigned B_UP = 2;
   localparam int unsigned B_DN = 3;
   localparam int unsigned B_FAN = 4;
   localparam int unsigned B_TMR = 5;
   localparam int unsigned B_FUNC = 6;
   localparam int unsigned B_OK = 7;

   localparam int unsigned NV_ON = 0;
   localparam int unsigned NV_MODE = 1;
   localparam int unsigned NV_SP = 4;
   localparam int unsigned NV_FAN = 9;
   localparam int unsigned NV_LOCK = 11;
   localparam int unsigned NV_MEM = 12;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] ADDR_ERR    = 8'h08;
   localparam int unsigned CTRL_SHIELD = 0;
   localparam logic        CTRL_RST   = 1'h0;

   typedef enum logic [2:0] {
      MD_AUTO = 3'h0, MD_COOL = 3'h1, MD_DRY = 3'h2, MD_FAN = 3'h3, MD_HEAT = 3'h4
   } mode_t;
   typedef enum logic [1:0] {
      FS_HIGH = 2'h0, FS_MID = 2'h1, FS_LOW = 2'h2, FS_AUTO = 2'h3
   } fan_t;
   typedef enum logic [1:0] {
      FN_SWING = 2'h0, FN_SLEEP = 2'h1, FN_BOOST = 2'h2, FN_DRY = 2'h3
   } func_t;
   typedef enum logic [1:0] {
      T_IDLE = 2'h0, T_ENTRY = 2'h1, T_SET = 2'h2
   } tmr_st_t;
   typedef enum logic [0:0] {
      F_IDLE = 1'h0, F_SEL = 1'h1
   } fn_st_t;
endpackage : hvac_keypad_pkg
`default_nettype wire

// [core/hvac_keypad_setting_controller.sv]
// Keypad and settings state machine of a wall climate panel, with a
// Wishbone classic slave. Buttons and error lines are asynchronous pins;
// the main board reads the settings outputs and keeps the saved word.
`default_nettype none
// How it works
// RULE1: Power press toggles the unit on and off.
// RULE2: Mode press while on cycles auto, cool, dry, fan, heat.
// RULE3: Up/down step setpoint one degree, repeating every half second when held.
// RULE4: Setpoint stays within 16 to 30 degrees outside auto.
// RULE5: Setpoint steps are ignored in auto mode.
// RULE6: Fan press while on cycles high, middle, low, auto.
// RULE7: Timer press with none pending opens off-timer when on, on-timer when off.
// RULE8: Timer entry flashes hours, up/down adjust, timer press commits.
// RULE9: Timer press with a timer set cancels it and blanks hours.
// RULE10: Timer spans half hour to 24 hours in half hour steps.
// RULE11: Function press picks swing, sleep, boost, dry; confirm toggles the pick.
// RULE12: Function menu leaves on confirm or after five idle seconds.
// RULE13: Sleep in cool or dry raises setpoint a degree per hour, twice.
// RULE14: Sleep in heat lowers setpoint a degree per hour, twice.
// RULE15: Boost only offered and confirmed in cool or heat.
// RULE16: Coil dry only offered and enabled in cool or dry.
// RULE17: Off with coil dry runs low fan two minutes, else fan stops.
// RULE18: Up plus down held five seconds toggles key lock, when allowed.
// RULE19: Key lock discards all presses except the unlocking hold.
// RULE20: Mode plus up held five seconds while off toggles memory.
// RULE21: Restore saved state on power return only if memory enabled.
// RULE22: Several active errors are shown in turn.
// RULE23: A timed hold restarts if any button of it is released.
// RULE24: Buttons are debounced, one action per press.
module hvac_keypad_setting_controller #(
   parameter int unsigned TICK_CYC = hvac_keypad_pkg::TICK_CYC,
   parameter int unsigned HOUR_TK  = hvac_keypad_pkg::HOUR_TK,
   parameter int unsigned HALFH_TK = hvac_keypad_pkg::HALFH_TK,
   parameter int unsigned BLOW_TK  = hvac_keypad_pkg::BLOW_TK
) (
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   input  wire logic [7:0]        i_btn,
   input  wire logic [7:0]        i_err,
   input  wire logic              i_nv_load,
   input  wire logic [15:0]       i_nv_word,
   input  wire logic              i_wb_cyc,
   input  wire logic              i_wb_stb,
   input  wire logic              i_wb_we,
   input  wire logic [3:0]        i_wb_sel,
   input  wire logic [7:0]        i_wb_adr,
   input  wire logic [31:0]       i_wb_dat,
   output logic [31:0]            o_wb_dat,
   output logic                   o_wb_ack,
   output logic                   o_power,
   output hvac_keypad_pkg::mode_t o_mode,
   output logic [4:0]             o_setpoint,
   output hvac_keypad_pkg::fan_t  o_fan,
   output logic                   o_fan_run,
   output logic                   o_swing,
   output logic                   o_sleep,
   output logic                   o_boost,
   output logic                   o_coil_dry,
   output logic                   o_blow_ind,
   output logic                   o_lock,
   output logic                   o_memory,
   output logic [5:0]             o_timer_hh,
   output logic                   o_timer_on_ind,
   output logic                   o_timer_off_ind,
   output logic                   o_timer_flash,
   output hvac_keypad_pkg::func_t o_func_sel,
   output logic                   o_func_flash,
   output logic [2:0]             o_err_idx,
   output logic                   o_err_valid,
   output logic [15:0]            o_nv_word
);
   import hvac_keypad_pkg::*;

   logic [31:0] tick_cnt_r;
   logic        tick_r;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else begin
         tick_r <= (tick_cnt_r == TICK_CYC - 1);
         tick_cnt_r <= (tick_cnt_r == TICK_CYC - 1) ? 32'h0 : tick_cnt_r + 32'h1;
      end
   end
   // Per-button sync and debounce; a level must hold DEB_TK ticks
   logic [7:0] db;
   logic [7:0] db_d_r;
   logic [7:0] prs;
   genvar g;
   for (g = 0; g < 8; g++) begin : g_btn
      logic       s1_r, s2_r, db_r;
      logic [7:0] cnt_r;
      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            db_r  <= 1'b0;
            cnt_r <= 8'h0;
         end else begin
            s1_r <= i_btn[g];
            s2_r <= s1_r;
            if (s2_r == db_r) cnt_r <= 8'h0;
            else if (tick_r) cnt_r <= (cnt_r == 8'(DEB_TK - 1)) ? 8'h0 : cnt_r + 8'h1;
            if (s2_r != db_r && tick_r && cnt_r == 8'(DEB_TK - 1)) db_r <= s2_r; // RULE24
         end
      end
      assign db[g] = db_r;
   end
   logic [7:0] err_s1_r, err_s_r, ctrl_r;
   logic [15:0] nv_s1_r, nv_s_r;
   logic nvl_s1_r, nvl_s_r, nvl_d_r;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {db_d_r, err_s1_r, err_s_r}  <= 24'h0;
         {nv_s1_r, nv_s_r}            <= 32'h0;
         {nvl_s1_r, nvl_s_r, nvl_d_r} <= 3'h0;
      end else begin
         db_d_r   <= db;
         err_s1_r <= i_err;
         err_s_r  <= err_s1_r;
         nv_s1_r  <= i_nv_word;
         nv_s_r   <= nv_s1_r;
         nvl_s1_r <= i_nv_load;
         nvl_s_r  <= nvl_s1_r;
         nvl_d_r  <= nvl_s_r;
      end
   end
   logic lock_r, on_r;
   logic [7:0] act;
   assign prs = db & ~db_d_r; // RULE24
   // Locked or shielded panels drop every single press
   assign act = prs & {8{~lock_r & ~ctrl_r[CTRL_SHIELD]}}; // RULE19
   // Held-repeat stepping; both held means a combination, not a step
   logic [7:0] rep_cnt_r;
   logic       rep_fire;
   logic       one_held;
   assign one_held = db[B_UP] ^ db[B_DN];
   assign rep_fire = tick_r & one_held & (rep_cnt_r == 8'(REP_TK - 1));
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rep_cnt_r <= 8'h0;
      end else if (!one_held || rep_fire) begin
         rep_cnt_r <= 8'h0;
      end else if (tick_r) begin
         rep_cnt_r <= rep_cnt_r + 8'h1;
      end
   end
   logic step_up, step_dn;
   assign step_up = act[B_UP] | (rep_fire & db[B_UP] & ~lock_r); // RULE3 RULE10
   assign step_dn = act[B_DN] | (rep_fire & db[B_DN] & ~lock_r); // RULE3 RULE10
   // Combination holds: counters restart on any release, fire once
   logic [9:0] lk_cnt_r, mm_cnt_r;
   logic       lk_fire, mm_fire;
   logic       lk_held, mm_held;
   assign lk_held = db[B_UP] & db[B_DN] & ~ctrl_r[CTRL_SHIELD];
   assign mm_held = db[B_MODE] & db[B_UP] & ~on_r & ~lock_r & ~ctrl_r[CTRL_SHIELD];
   assign lk_fire = tick_r & lk_held & (lk_cnt_r == 10'(HOLD_TK - 1));
   assign mm_fire = tick_r & mm_held & (mm_cnt_r == 10'(HOLD_TK - 1));
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lk_cnt_r <= 10'h0;
         mm_cnt_r <= 10'h0;
      end else begin
         if (!lk_held) lk_cnt_r <= 10'h0; // RULE23
         else if (tick_r && lk_cnt_r != 10'(HOLD_TK)) lk_cnt_r <= lk_cnt_r + 10'h1;
         if (!mm_held) mm_cnt_r <= 10'h0; // RULE23
         else if (tick_r && mm_cnt_r != 10'(HOLD_TK)) mm_cnt_r <= mm_cnt_r + 10'h1;
      end
   end
   // Timer entry and countdown
   tmr_st_t tst_r;
   logic [5:0]  tval_r;
   logic        tkind_on_r;
   logic [31:0] tcnt_r;
   logic        t_expire;
   assign t_expire = (tst_r == T_SET) & tick_r & (tcnt_r == HALFH_TK - 1) &
                     (tval_r == TMR_MIN);
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tst_r      <= T_IDLE;
         tval_r     <= TMR_RST;
         tkind_on_r <= 1'b0;
         tcnt_r     <= 32'h0;
      end else begin
         case (tst_r)
            T_IDLE: begin
               if (act[B_TMR]) begin
                  tst_r      <= T_ENTRY; // RULE7
                  tkind_on_r <= ~on_r;
               end
            end
            T_ENTRY: begin
               if (act[B_TMR]) begin
                  tst_r  <= T_SET; // RULE8
                  tcnt_r <= 32'h0;
               end else if (step_up && tval_r != TMR_MAX) tval_r <= tval_r + 6'h1; // RULE10
               else if (step_dn && tval_r != TMR_MIN) tval_r <= tval_r - 6'h1; // RULE10
            end
            T_SET: begin
               if (act[B_TMR] || t_expire) tst_r <= T_IDLE; // RULE9
               else if (tick_r && tcnt_r == HALFH_TK - 1) begin
                  tcnt_r <= 32'h0;
                  tval_r <= tval_r - 6'h1;
               end else if (tick_r) tcnt_r <= tcnt_r + 32'h1;
            end
            default: tst_r <= T_IDLE;
         endcase
      end
   end
   // Function menu
   mode_t  mode_r;
   fn_st_t fst_r;
   func_t  fsel_r, fnext;
   logic [9:0] fto_r;
   logic [3:0] avail;
   always_comb begin
      logic [1:0] k;
      k = 2'h0;
      avail = {(mode_r == MD_COOL) | (mode_r == MD_DRY),  // RULE16
               (mode_r == MD_COOL) | (mode_r == MD_HEAT), // RULE15
               2'b11};
      fnext = FN_SWING;
      for (int i = 3; i >= 0; i--) begin
         k = (fst_r == F_IDLE) ? 2'(i) : 2'(fsel_r + 2'(i) + 2'h1);
         if (avail[k]) begin
            fnext = func_t'(k);
         end
      end
   end
   logic f_ok;
   assign f_ok = (fst_r == F_SEL) & act[B_OK] & avail[fsel_r]; // RULE11
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fst_r  <= F_IDLE;
         fsel_r <= FN_SWING;
         fto_r  <= 10'h0;
      end else if (!on_r) begin
         fst_r <= F_IDLE;
         fto_r <= 10'h0;
      end else if (act[B_FUNC]) begin
         fst_r  <= F_SEL; // RULE11
         fsel_r <= fnext;
         fto_r  <= 10'h0;
      end else if (fst_r == F_SEL) begin
         if (act[B_OK] || fto_r == 10'(FUNC_TK - 1)) begin
            fst_r <= F_IDLE; // RULE12
            fto_r <= 10'h0;
         end else if (tick_r) fto_r <= fto_r + 10'h1;
      end
   end
   // Unit settings
   fan_t fan_r;
   logic [4:0] sp_r;
   logic swing_r, sleep_r, boost_r, dry_r, mem_r;
   logic [31:0] blow_r;
   logic pwr_tgl, fault, nv_edge;
   assign fault   = |err_s_r;
   assign nv_edge = nvl_s_r & ~nvl_d_r;
   assign pwr_tgl = act[B_PWR] | (t_expire & (on_r != tkind_on_r)); // RULE1
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {on_r, swing_r, sleep_r, boost_r, dry_r, lock_r, mem_r} <= 7'h0;
         mode_r  <= MD_AUTO;
         sp_r    <= SP_RST;
         fan_r   <= FS_AUTO;
         blow_r  <= 32'h0;
      end else if (nv_edge) begin
         on_r   <= nv_s_r[NV_MEM] & nv_s_r[NV_ON]; // RULE21
         mem_r  <= nv_s_r[NV_MEM];
         if (nv_s_r[NV_MEM]) begin
            mode_r <= (nv_s_r[NV_MODE+:3] > 3'(MD_HEAT)) ? MD_AUTO
                      : mode_t'(nv_s_r[NV_MODE+:3]);
            sp_r   <= (nv_s_r[NV_SP+:5] < SP_MIN || nv_s_r[NV_SP+:5] > SP_MAX)
                      ? SP_RST : nv_s_r[NV_SP+:5];
            fan_r  <= fan_t'(nv_s_r[NV_FAN+:2]);
            lock_r <= nv_s_r[NV_LOCK];
         end
      end else begin
         if (pwr_tgl) begin
            on_r <= ~on_r;
            // Coil drying only starts from an on-to-off change
            blow_r <= (on_r && dry_r) ? BLOW_TK : 32'h0; // RULE17
         end else if (tick_r && blow_r != 32'h0) blow_r <= blow_r - 32'h1;
         if (lk_fire && (lock_r || !on_r || !fault)) lock_r <= ~lock_r; // RULE18
         if (mm_fire) mem_r <= ~mem_r; // RULE20
         if (on_r && act[B_MODE])
            mode_r <= (mode_r == MD_HEAT) ? MD_AUTO : mode_t'(mode_r + 3'h1); // RULE2
         if (on_r && act[B_FAN]) fan_r <= fan_t'(fan_r + 2'h1); // RULE6
         if (on_r && tst_r != T_ENTRY && mode_r != MD_AUTO) begin // RULE5
            if (step_up && sp_r < SP_MAX) sp_r <= sp_r + 5'h1; // RULE3 RULE4
            else if (step_dn && sp_r > SP_MIN) sp_r <= sp_r - 5'h1; // RULE3 RULE4
         end
         if (f_ok) begin
            case (fsel_r)
               FN_SWING: swing_r <= ~swing_r;
               FN_SLEEP: sleep_r <= ~sleep_r;
               FN_BOOST: boost_r <= ~boost_r;
               FN_DRY:   dry_r   <= ~dry_r;
               default:  swing_r <= swing_r;
            endcase
         end
         // Leaving a mode drops features it cannot carry
         if (!avail[FN_BOOST]) boost_r <= 1'b0; // RULE15
         if (!avail[FN_DRY]) dry_r <= 1'b0; // RULE16
      end
   end
   // Sleep drift of the effective setpoint
   logic [1:0]  drift_r;
   logic [31:0] hr_r;
   logic        drift_on;
   assign drift_on = on_r & sleep_r &
                     (mode_r == MD_COOL || mode_r == MD_DRY || mode_r == MD_HEAT);
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         drift_r <= 2'h0;
         hr_r    <= 32'h0;
      end else if (!drift_on) begin
         drift_r <= 2'h0;
         hr_r    <= 32'h0;
      end else if (tick_r && drift_r != DRIFT_MAX) begin
         drift_r <= (hr_r == HOUR_TK - 1) ? drift_r + 2'h1 : drift_r; // RULE13 RULE14
         hr_r    <= (hr_r == HOUR_TK - 1) ? 32'h0 : hr_r + 32'h1;
      end
   end
   // Error rotation; empty slots are skipped one tick each
   logic [2:0] eidx_r;
   logic [9:0] rot_r;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         eidx_r <= 3'h0;
         rot_r  <= 10'h0;
      end else if (tick_r) begin
         if (!err_s_r[eidx_r] || rot_r == 10'(ROT_TK - 1)) eidx_r <= eidx_r + 3'h1; // RULE22
         rot_r <= (!err_s_r[eidx_r] || rot_r == 10'(ROT_TK - 1)) ? 10'h0 : rot_r + 10'h1;
      end
   end
   // Wishbone classic slave, one wait state, unmapped reads give zero
   logic wb_req;
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
         ctrl_r   <= {7'h0, CTRL_RST};
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= 32'h0;
         if (o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we &&
             i_wb_adr == ADDR_CTRL && i_wb_sel[0]) begin
            ctrl_r <= {7'h0, i_wb_dat[CTRL_SHIELD]};
         end
         if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
               ADDR_CTRL: o_wb_dat <= {24'h0, ctrl_r};
               ADDR_STAT: o_wb_dat <= {16'h0, o_nv_word};
               ADDR_ERR:  o_wb_dat <= {21'h0, eidx_r, err_s_r};
               default:   o_wb_dat <= 32'h0;
            endcase
         end
      end
   end
   // Registered outputs
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_mode <= MD_AUTO;
         o_setpoint <= SP_RST;
         o_fan <= FS_AUTO;
         o_func_sel <= FN_SWING;
         {o_power, o_fan_run, o_swing, o_sleep, o_boost, o_coil_dry, o_blow_ind} <= 7'h0;
         {o_lock, o_memory, o_timer_on_ind, o_timer_off_ind, o_timer_flash} <= 5'h0;
         {o_func_flash, o_err_valid, o_err_idx, o_timer_hh} <= 11'h0;
         o_nv_word <= 16'h0;
      end else begin
         o_power <= on_r;
         o_mode <= mode_r;
         o_setpoint <= (mode_r == MD_HEAT) ? sp_r - {3'h0, drift_r} // RULE14
                                           : sp_r + {3'h0, drift_r}; // RULE13
         o_fan <= (!on_r && blow_r != 32'h0) ? FS_LOW : fan_r; // RULE17
         o_fan_run <= on_r | (blow_r != 32'h0); // RULE17
         o_blow_ind <= ~on_r & (blow_r != 32'h0);
         o_swing <= swing_r;
         o_sleep <= sleep_r;
         o_boost <= boost_r;
         o_coil_dry <= dry_r;
         o_lock <= lock_r;
         o_memory <= mem_r;
         o_timer_hh <= (tst_r == T_IDLE) ? 6'h0 : tval_r; // RULE9
         o_timer_on_ind <= (tst_r != T_IDLE) & tkind_on_r;
         o_timer_off_ind <= (tst_r != T_IDLE) & ~tkind_on_r;
         o_timer_flash <= (tst_r == T_ENTRY); // RULE8
         o_func_sel <= fsel_r;
         o_func_flash <= (fst_r == F_SEL);
         o_err_idx <= eidx_r;
         o_err_valid <= err_s_r[eidx_r];
         o_nv_word <= {3'h0, mem_r, lock_r, fan_r, sp_r, mode_r, on_r};
      end
   end
endmodule : hvac_keypad_setting_controller
`default_nettype wire

// [verification/hvac_board_model.sv]
// Main board stand-in: passes error lines, keeps the saved settings word.
// Assumes the bench raises i_fail for the whole power outage.
`default_nettype none
module hvac_board_model (
   input  wire logic        i_clk,
   input  wire logic        i_fail,
   input  wire logic [7:0]  i_err_req,
   input  wire logic [15:0] i_word,
   output logic [7:0]       o_err,
   output logic             o_nv_load,
   output logic [15:0]      o_nv_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  hold_r = 4'h0;
   logic        load_r = 1'b1;
   logic [15:0] word_r = 16'h0000;
   assign o_err = i_err_req;
   assign o_nv_load = load_r;
   assign o_nv_word = word_r;
   // Freeze the copy until the panel has reloaded it
   always_ff @(posedge i_clk) begin
      if (i_fail) begin
         hold_r <= 4'hf;
      end else if (hold_r != 4'h0) begin
         hold_r <= hold_r - 4'h1;
      end else begin
         word_r <= i_word;
      end
      load_r <= !i_fail && (hold_r < 4'hc);
   end
endmodule : hvac_board_model
`default_nettype wire

// [verification/hvac_keypad_checker.sv]
// Port checker for the keypad controller, bound to its top module.
// Assumes the bench runs no timer or restore while these states are held.
`default_nettype none
module hvac_keypad_checker
   import hvac_keypad_pkg::*;
(
   input wire logic                   i_clk,
   input wire logic                   i_nrst,
   input wire logic                   o_power,
   input wire hvac_keypad_pkg::mode_t o_mode,
   input wire logic [4:0]             o_setpoint,
   input wire hvac_keypad_pkg::fan_t  o_fan,
   input wire logic                   o_fan_run,
   input wire logic                   o_sleep,
   input wire logic                   o_boost,
   input wire logic                   o_coil_dry,
   input wire logic                   o_blow_ind,
   input wire logic                   o_lock
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   chk_sp_range: assert property (
      o_power && o_mode != MD_AUTO && !o_sleep |-> o_setpoint inside {[SP_MIN:SP_MAX]})
      else $error("setpoint outside range");
   chk_sp_step: assert property (
      o_power && $past(o_power) && o_mode != MD_AUTO && $stable(o_mode) && !o_sleep
      && $stable(o_sleep) && $changed(o_setpoint)
      |-> (o_setpoint - $past(o_setpoint)) inside {5'h01, 5'h1f})
      else $error("setpoint moved more than one degree");
   chk_auto_hold: assert property (
      o_mode == MD_AUTO && $past(o_mode) == MD_AUTO && !o_sleep && $stable(o_sleep)
      |-> $stable(o_setpoint)) else $error("setpoint moved in auto");
   chk_off_mode: assert property (
      !o_power && !$past(o_power) |-> $stable(o_mode)) else $error("mode moved while off");
   chk_boost_modes: assert property (
      o_boost && $stable(o_mode) |-> o_mode inside {MD_COOL, MD_HEAT})
      else $error("boost in wrong mode");
   chk_coil_modes: assert property (
      o_coil_dry && $stable(o_mode) |-> o_mode inside {MD_COOL, MD_DRY})
      else $error("coil dry in wrong mode");
   chk_blow_fan: assert property (
      o_blow_ind |-> !o_power && o_fan == FS_LOW && o_fan_run) else $error("drying fan wrong");
   chk_lock_freeze: assert property (
      o_lock && $past(o_lock) |-> $stable(o_power) && $stable(o_mode))
      else $error("setting moved while locked");
endmodule : hvac_keypad_checker
bind hvac_keypad_setting_controller hvac_keypad_checker u_chk (.i_clk, .i_nrst, .o_power,
   .o_mode, .o_setpoint, .o_fan, .o_fan_run, .o_sleep, .o_boost, .o_coil_dry, .o_blow_ind,
   .o_lock);
`default_nettype wire

// [verification/hvac_keypad_setting_controller_tb_top.sv]
// Self-checking bench for the keypad controller with the board model.
// Assumes shortened tick, hour, half hour and drying counts set below.
`default_nettype none
module hvac_keypad_setting_controller_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import hvac_keypad_pkg::*;
   logic i_clk, i_nrst, i_fail, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, o_power, o_fan_run;
   logic o_swing, o_sleep, o_boost, o_coil_dry, o_blow_ind, o_lock, o_memory, i_nv_load;
   logic o_timer_on_ind, o_timer_off_ind, o_timer_flash, o_func_flash;
   logic [7:0]  i_btn, i_err, i_wb_adr, err_req;
   logic [31:0] i_wb_dat, o_wb_dat, rd;
   logic [15:0] i_nv_word, o_nv_word;
   logic [5:0]  o_timer_hh;
   logic [4:0]  o_setpoint;
   mode_t       o_mode;
   fan_t        o_fan;
   func_t       o_func_sel;
   int          err_total = 0;
   int          comparisons = 0;
   int          cyc_n = 0;
   hvac_keypad_setting_controller #(.TICK_CYC(2), .HOUR_TK(20), .HALFH_TK(10), .BLOW_TK(30))
   u_dut (.i_clk, .i_nrst, .i_btn, .i_err, .i_nv_load, .i_nv_word, .i_wb_cyc, .i_wb_stb,
      .i_wb_we, .i_wb_sel(4'hf), .i_wb_adr, .i_wb_dat, .o_wb_dat, .o_wb_ack, .o_power, .o_mode,
      .o_setpoint, .o_fan, .o_fan_run, .o_swing, .o_sleep, .o_boost, .o_coil_dry, .o_blow_ind,
      .o_lock, .o_memory, .o_timer_hh, .o_timer_on_ind, .o_timer_off_ind, .o_timer_flash,
      .o_func_sel, .o_func_flash, .o_err_idx(), .o_err_valid(), .o_nv_word);
   hvac_board_model u_board (.i_clk, .i_fail, .i_err_req(err_req), .i_word(o_nv_word),
      .o_err(i_err), .o_nv_load(i_nv_load), .o_nv_word(i_nv_word));
   always #5 i_clk = ~i_clk;
   task automatic wrap_up;
      $display("Comparisons %0d, errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask : cyc
   // Hold long enough to clear the shortened debounce on press and release
   task automatic press(input logic [7:0] b, input int n = 30);
      i_btn <= b;
      cyc(n);
      i_btn <= 8'h00;
      cyc(30);
   endtask : press
   task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_adr <= a;
      i_wb_we <= we;
      i_wb_dat <= d;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_clk);
   endtask : wb
   always @(posedge i_clk) begin
      cyc_n++;
      if (cyc_n > 40000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      {i_clk, i_nrst, i_fail, i_wb_cyc, i_wb_stb, i_wb_we} = 6'h00;
      {i_btn, err_req, i_wb_adr, i_wb_dat} = 56'h0;
      cyc(3);
      i_nrst <= 1'b1;
      cyc(2);
      wb(ADDR_STAT, 1'b0, 32'h0);
      chk(rd, 32'h0000_0780);
      wb(8'h0c, 1'b0, 32'h0);
      chk(rd, 32'h0);
      wb(ADDR_CTRL, 1'b1, 32'h1);
      press(8'h01);
      chk(o_power, 1'b0);
      wb(ADDR_CTRL, 1'b1, 32'h0);
      press(8'h01);
      chk(o_power, 1'b1);
      for (int m = 1; m <= 5; m++) begin
         press(8'h02);
         chk(o_mode, m % 5);
      end
      press(8'h04);
      chk(o_setpoint, SP_RST);
      press(8'h02);
      for (int i = 0; i < 7; i++) press(8'h04);
      chk(o_setpoint, SP_MAX);
      press(8'h08, 270);
      chk(o_setpoint, 5'h1b);
      for (int i = 0; i < 4; i++) begin
         press(8'h10);
         chk(o_fan, i);
      end
      press(8'h40);
      chk({o_func_flash, o_func_sel}, {1'b1, FN_SWING});
      press(8'h80);
      chk({o_swing, o_func_flash}, 2'b10);
      for (int k = 2; k <= 4; k++) begin
         for (int j = 0; j < k; j++) press(8'h40);
         press(8'h80);
      end
      cyc(100);
      chk({o_sleep, o_boost, o_coil_dry, o_setpoint}, {3'b111, 5'h1d});
      press(8'h02);
      chk({o_boost, o_coil_dry}, 2'b01);
      press(8'h40);
      cyc(1050);
      chk(o_func_flash, 1'b0);
      press(8'h01);
      chk({o_blow_ind, o_fan}, {1'b1, FS_LOW});
      cyc(60);
      chk(o_fan_run, 1'b0);
      press(8'h20);
      chk({o_timer_on_ind, o_timer_off_ind, o_timer_flash}, 3'b101);
      for (int i = 0; i < 3; i++) press(8'h04);
      chk(o_timer_hh, 6'h05);
      press(8'h20);
      chk(o_timer_flash, 1'b0);
      press(8'h20);
      chk({o_timer_hh, o_timer_on_ind}, 7'h0);
      press(8'h06, 1100);
      chk(o_memory, 1'b1);
      press(8'h0c, 600);
      press(8'h0c, 600);
      chk(o_lock, 1'b0);
      press(8'h0c, 1100);
      chk(o_lock, 1'b1);
      press(8'h01);
      chk(o_power, 1'b0);
      press(8'h0c, 1100);
      chk(o_lock, 1'b0);
      press(8'h01);
      i_fail <= 1'b1;
      i_nrst <= 1'b0;
      cyc(3);
      chk(o_power, 1'b0);
      i_fail <= 1'b0;
      i_nrst <= 1'b1;
      cyc(30);
      chk({o_power, o_mode}, {1'b1, MD_DRY});
      err_req <= 8'h05;
      cyc(10);
      wb(ADDR_ERR, 1'b0, 32'h0);
      chk(rd[7:0], 8'h05);
      press(8'h0c, 1100);
      chk(o_lock, 1'b0);
      wrap_up();
   end
endmodule : hvac_keypad_setting_controller_tb_top
`default_nettype wire
